// [rtl/tmc_pkg.sv]
/*
 * Shared constants and types for the timer mode and clock control block.
 * Assumes a 32-bit classic Wishbone register bus, where a register's index times four
 * gives its byte address.
 */
`default_nettype none
package tmc_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [5:0] IDX_CAPTURE = 6'h22;
   localparam logic [5:0] IDX_CMP_B   = 6'h24;
   localparam logic [5:0] IDX_CMP_A   = 6'h26;
   localparam logic [5:0] IDX_COUNT   = 6'h28;
   localparam logic [5:0] IDX_CTRL_B  = 6'h2d;
   localparam logic [5:0] IDX_CTRL_A  = 6'h2e;
   localparam logic [5:0] IDX_FLAGS   = 6'h30;
   localparam logic [5:0] IDX_PIN_DIR = 6'h31;
   // Reset values and implemented-bit masks of the control registers.
   localparam logic [7:0] CTRL_A_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   localparam logic [7:0] CTRL_A_MASK  = 8'hf3;
   localparam logic [7:0] CTRL_B_MASK  = 8'hdf;
   // Field positions.
   localparam int CA_MODE_A   = 6;
   localparam int CA_MODE_B   = 4;
   localparam int CB_FILT_EN  = 7;
   localparam int CB_EDGE_SEL = 6;
   localparam int CB_WAVE_HI  = 3;
   // Flag bit positions in the flag register.
   localparam int FLG_OVF     = 0;
   localparam int FLG_MATCH_A = 1;
   localparam int FLG_MATCH_B = 2;
   localparam int FLG_CAPTURE = 5;
   // Counter landmarks.
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX    = 16'hffff;
   localparam logic [15:0] TOP_8  = 16'h00ff;
   localparam logic [15:0] TOP_9  = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   // Clock select codes.
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // Samples the capture filter needs before it follows the pin.
   localparam int FILT_SAMPLES = 4;

   typedef enum logic [2:0] {
      TMC_NORMAL = 3'h0,
      TMC_CTC    = 3'h1,
      TMC_FAST   = 3'h3,
      TMC_PHASE  = 3'h2,
      TMC_PFC    = 3'h6,
      TMC_RESV   = 3'h7
   } tmc_kind_t;

   typedef enum logic [1:0] {
      PT_IMM = 2'h0,
      PT_MAX = 2'h1,
      PT_TOP = 2'h3,
      PT_BOT = 2'h2
   } tmc_point_t;

   // Complete state of the timer block.
   typedef struct packed {
      logic [7:0]       ctrl_a;
      logic [7:0]       ctrl_b;
      logic [15:0]      count;
      logic [1:0][15:0] cmp;
      logic [1:0][15:0] cmp_buf;
      logic [15:0]      capture;
      logic             down;
      logic [5:0]       flags;
      logic [1:0]       pin_dir;
      logic [9:0]       presc;
      logic             ext_prev;
      logic [3:0]       cap_hist;
      logic             cap_filt;
      logic             cap_prev;
      logic             block;
      logic [1:0]       wave;
      logic [1:0]       oe;
      logic [1:0]       ovr;
      logic             ack;
      logic [31:0]      rdata;
   } tmc_state_t;
endpackage
`default_nettype wire

// [rtl/tmc_timer.sv]
/*
 * Sixteen-bit timer with two compare channels, input capture and clock selection.
 * Assumes a classic Wishbone master on clk_sys, and pins synchronous to clk_sys.
 */
// The implementer's own choice: the Wishbone slave port.
`default_nettype none
module tmc_timer
   import tmc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Timer pins.
   input  wire logic        capture_input_pin,
   input  wire logic        external_count_pin,
   output logic             wave_out_a,
   output logic             wave_oe_a,
   output logic             port_override_a,
   output logic             wave_out_b,
   output logic             wave_oe_b,
   output logic             port_override_b
);

   tmc_state_t q;
   tmc_state_t s;
   logic [3:0]  waveform_mode_field;
   tmc_kind_t   kind;
   tmc_point_t  upd_pt;
   tmc_point_t  ovf_pt;
   logic [15:0] top;
   logic        icr_top;
   logic        tick;
   logic        at_top;
   logic        at_bot;
   logic        req;
   logic        wr;
   logic [5:0]  idx;
   logic [1:0]  match;
   logic        cap_edge;
   logic        cap_wr;
   logic        cnt_wr;
   logic [1:0]  com;
   logic        pwm;
   logic        conn;

   // Bus request decode.
   assign req = wb_cyc_i && wb_stb_i && !q.ack;
   assign wr  = req && wb_we_i;
   assign idx = wb_adr_i[7:2];

   // Mode decode: top source, buffer update point and overflow point.
   always_comb
   begin
      waveform_mode_field = {q.ctrl_b[CB_WAVE_HI +: 2], q.ctrl_a[1:0]};
      kind    = TMC_NORMAL;
      top     = MAX;
      upd_pt  = PT_IMM;
      ovf_pt  = PT_MAX;
      icr_top = 1'b0;
      case (waveform_mode_field)
         4'h0: top = MAX;
         4'h1, 4'h2, 4'h3:
         begin
            kind   = TMC_PHASE;
            top    = (waveform_mode_field == 4'h1) ? TOP_8 :
                     (waveform_mode_field == 4'h2) ? TOP_9 : TOP_10;
            upd_pt = PT_TOP;
            ovf_pt = PT_BOT;
         end
         4'h4:
         begin
            kind = TMC_CTC;
            top  = q.cmp[0];
         end
         4'h5, 4'h6, 4'h7:
         begin
            kind   = TMC_FAST;
            top    = (waveform_mode_field == 4'h5) ? TOP_8 :
                     (waveform_mode_field == 4'h6) ? TOP_9 : TOP_10;
            upd_pt = PT_TOP;
            ovf_pt = PT_TOP;
         end
         4'h8, 4'h9:
         begin
            kind    = TMC_PFC;
            icr_top = !waveform_mode_field[0];
            top     = waveform_mode_field[0] ? q.cmp[0] : q.capture;
            upd_pt  = PT_BOT;
            ovf_pt  = PT_BOT;
         end
         4'ha, 4'hb:
         begin
            kind    = TMC_PHASE;
            icr_top = !waveform_mode_field[0];
            top     = waveform_mode_field[0] ? q.cmp[0] : q.capture;
            upd_pt  = PT_TOP;
            ovf_pt  = PT_BOT;
         end
         4'hc:
         begin
            kind    = TMC_CTC;
            icr_top = 1'b1;
            top     = q.capture;
         end
         4'hd: kind = TMC_RESV;
         default:
         begin
            kind    = TMC_FAST;
            icr_top = !waveform_mode_field[0];
            top     = waveform_mode_field[0] ? q.cmp[0] : q.capture;
            upd_pt  = PT_TOP;
            ovf_pt  = PT_TOP;
         end
      endcase
   end

   // Timer clock enable from the prescaler or the external pin.
   always_comb
   begin
      case (q.ctrl_b[2:0])
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = (q.presc[2:0] == 3'h7);
         CS_DIV64:    tick = (q.presc[5:0] == 6'h3f);
         CS_DIV256:   tick = (q.presc[7:0] == 8'hff);
         CS_DIV1024:  tick = (q.presc == 10'h3ff);
         CS_EXT_FALL: tick = q.ext_prev && !external_count_pin;
         CS_EXT_RISE: tick = !q.ext_prev && external_count_pin;
         default:     tick = 1'b0;
      endcase
      if (kind == TMC_RESV)
      begin
         tick = 1'b0;
      end
   end

   assign at_top = (q.count == top);
   assign at_bot = (q.count == BOTTOM);
   assign cnt_wr = wr && (idx == IDX_COUNT) && (wb_sel_i[1:0] != 2'h0);
   assign cap_wr = wr && (idx == IDX_CAPTURE) && (wb_sel_i[1:0] != 2'h0);
   // Capture edge after optional filtering; blocked while capture is top.
   assign cap_edge = !icr_top && (q.cap_filt != q.cap_prev) &&
                     (q.cap_filt == q.ctrl_b[CB_EDGE_SEL]);

   // Next-state logic for counter, waveforms, capture and registers.
   always_comb
   begin
      s = q;
      com = 2'h0;
      pwm = 1'b0;
      conn = 1'b0;
      s.presc = q.presc + 10'h001;
      s.ext_prev = external_count_pin;
      s.ack = req;
      // Software clears flags first so that a same-cycle event wins.
      if (wr && idx == IDX_FLAGS && wb_sel_i[0])
      begin
         s.flags = q.flags & ~wb_dat_i[5:0];
      end
      // Count sequence per mode.
      if (tick)
      begin
         s.block = 1'b0;
         case (kind)
            TMC_CTC, TMC_FAST: s.count = at_top ? BOTTOM : q.count + 16'h0001;
            TMC_PHASE, TMC_PFC:
            begin
               if (!q.down && at_top)
               begin
                  s.down = 1'b1;
                  s.count = q.count - 16'h0001;
               end
               else if (q.down && at_bot)
               begin
                  s.down = 1'b0;
                  s.count = q.count + 16'h0001;
               end
               else
               begin
                  s.count = q.down ? q.count - 16'h0001 : q.count + 16'h0001;
               end
            end
            default: s.count = q.count + 16'h0001;
         endcase
         // Overflow flag point.
         if ((ovf_pt == PT_MAX && q.count == MAX) || (ovf_pt == PT_TOP && at_top) ||
             (ovf_pt == PT_BOT && at_bot && q.down))
         begin
            s.flags[FLG_OVF] = 1'b1;
         end
         // Double-buffered compare update point.
         if ((upd_pt == PT_TOP && at_top) || (upd_pt == PT_BOT && at_bot && q.down))
         begin
            s.cmp = q.cmp_buf;
         end
      end
      // Compare channels and their waveform outputs.
      for (int c = 0; c < 2; c++)
      begin
         com = (c == 0) ? q.ctrl_a[CA_MODE_A +: 2] : q.ctrl_a[CA_MODE_B +: 2];
         pwm = (kind == TMC_FAST) || (kind == TMC_PHASE) || (kind == TMC_PFC);
         match[c] = tick && !q.block && (q.count == q.cmp[c]);
         conn = (com != 2'h0) &&
                !(pwm && com == 2'h1 && (!waveform_mode_field[3] || c == 1));
         if (match[c])
         begin
            s.flags[FLG_MATCH_A + c] = 1'b1;
         end
         if (!pwm)
         begin
            if (match[c] && com == 2'h1)
            begin
               s.wave[c] = !q.wave[c];
            end
            else if (match[c] && com[1])
            begin
               s.wave[c] = com[0];
            end
         end
         else if (com == 2'h1)
         begin
            if (match[c] && waveform_mode_field[3] && c == 0)
            begin
               s.wave[c] = !q.wave[c];
            end
         end
         else if (com[1] && kind == TMC_FAST)
         begin
            if (match[c] && q.cmp[c] != top)
            begin
               s.wave[c] = com[0];
            end
            if (tick && at_top)
            begin
               s.wave[c] = !com[0];
            end
         end
         else if (com[1] && match[c])
         begin
            s.wave[c] = q.down ^ com[0];
         end
         s.ovr[c] = conn;
         s.oe[c] = conn && q.pin_dir[c];
      end
      // Capture input filter and edge capture.
      s.cap_hist = {q.cap_hist[FILT_SAMPLES-2:0], capture_input_pin};
      s.cap_prev = q.cap_filt;
      if (!q.ctrl_b[CB_FILT_EN])
      begin
         s.cap_filt = capture_input_pin;
      end
      else if (s.cap_hist == {FILT_SAMPLES{1'b1}})
      begin
         s.cap_filt = 1'b1;
      end
      else if (s.cap_hist == {FILT_SAMPLES{1'b0}})
      begin
         s.cap_filt = 1'b0;
      end
      if (cap_edge)
      begin
         s.capture = q.count;
         s.flags[FLG_CAPTURE] = 1'b1;
      end
      // Register writes after the timer so that software wins on data.
      if (wr)
      begin
         if (idx == IDX_CTRL_A && wb_sel_i[0])
         begin
            s.ctrl_a = wb_dat_i[7:0] & CTRL_A_MASK;
         end
         else if (idx == IDX_CTRL_B && wb_sel_i[0])
         begin
            s.ctrl_b = wb_dat_i[7:0] & CTRL_B_MASK;
         end
         else if (idx == IDX_PIN_DIR && wb_sel_i[0])
         begin
            s.pin_dir = wb_dat_i[1:0];
         end
         for (int b = 0; b < 2; b++)
         begin
            if (wb_sel_i[b])
            begin
               if (idx == IDX_COUNT)
               begin
                  s.count[8*b +: 8] = wb_dat_i[8*b +: 8];
               end
               else if (idx == IDX_CAPTURE)
               begin
                  s.capture[8*b +: 8] = wb_dat_i[8*b +: 8];
               end
               else if (idx == IDX_CMP_A || idx == IDX_CMP_B)
               begin
                  s.cmp_buf[idx == IDX_CMP_B][8*b +: 8] = wb_dat_i[8*b +: 8];
               end
            end
         end
         // Immediate-update modes pass the buffer straight through.
         if (upd_pt == PT_IMM)
         begin
            s.cmp = s.cmp_buf;
         end
      end
      // A counter write suppresses the match on the next timer tick.
      if (cnt_wr)
      begin
         s.block = 1'b1;
      end
      // Read data; unmapped addresses read as zero.
      s.rdata = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         if (idx == IDX_CTRL_A)
         begin
            s.rdata[7:0] = q.ctrl_a;
         end
         else if (idx == IDX_CTRL_B)
         begin
            s.rdata[7:0] = q.ctrl_b;
         end
         else if (idx == IDX_COUNT)
         begin
            s.rdata[15:0] = q.count;
         end
         else if (idx == IDX_CMP_A)
         begin
            s.rdata[15:0] = q.cmp_buf[0];
         end
         else if (idx == IDX_CMP_B)
         begin
            s.rdata[15:0] = q.cmp_buf[1];
         end
         else if (idx == IDX_CAPTURE)
         begin
            s.rdata[15:0] = q.capture;
         end
         else if (idx == IDX_FLAGS)
         begin
            s.rdata[5:0] = q.flags;
         end
         else if (idx == IDX_PIN_DIR)
         begin
            s.rdata[1:0] = q.pin_dir;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '0;
         q.ctrl_a <= CTRL_A_RESET;
         q.ctrl_b <= CTRL_B_RESET;
      end
      else
      begin
         q <= s;
      end
   end

   // Outputs straight from flip-flops.
   assign wb_ack_o        = q.ack;
   assign wb_dat_o        = q.rdata;
   assign wave_out_a      = q.wave[0];
   assign wave_out_b      = q.wave[1];
   assign wave_oe_a       = q.oe[0];
   assign wave_oe_b       = q.oe[1];
   assign port_override_a = q.ovr[0];
   assign port_override_b = q.ovr[1];

   // Checks of timer behaviour.
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

   property p_oe_dir;
      // The enable was registered from last cycle's direction bit, so compare against that.
      wave_oe_a |-> port_override_a && $past(q.pin_dir[0]);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("driver on without direction");

   property p_nonpwm_clear;
      ((kind == TMC_NORMAL || kind == TMC_CTC) && q.ctrl_a[7:6] == 2'h2 && match[0])
         |=> !wave_out_a;
   endproperty
   a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("no clear on match");

   property p_fast_bottom;
      (kind == TMC_FAST && q.ctrl_a[5:4] == 2'h2 && tick && at_top) |=> wave_out_b;
   endproperty
   a_fast_bottom: assert property (p_fast_bottom) else $error("no set at bottom");

   property p_pc_down_set;
      (kind == TMC_PHASE && q.ctrl_a[5:4] == 2'h2 && match[1] && q.down) |=> wave_out_b;
   endproperty
   a_pc_down_set: assert property (p_pc_down_set) else $error("no set on down match");

   property p_normal_wrap;
      (kind == TMC_NORMAL && tick && q.count == MAX && !cnt_wr)
         |=> q.count == BOTTOM && q.flags[FLG_OVF];
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("bad wrap at max");

   property p_ctc_clear;
      (kind == TMC_CTC && tick && at_top && !cnt_wr) |=> q.count == BOTTOM;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("no clear at top");

   property p_filter;
      ($past(q.ctrl_b[CB_FILT_EN]) && q.cap_filt != $past(q.cap_filt))
         |-> q.cap_hist == {4{q.cap_filt}};
   endproperty
   a_filter: assert property (p_filter) else $error("filter changed early");

   property p_capture;
      cap_edge && !cap_wr |=> q.capture == $past(q.count) && q.flags[FLG_CAPTURE];
   endproperty
   a_capture: assert property (p_capture) else $error("capture lost");

   property p_icr_top_no_cap;
      (icr_top && !cap_wr) |=> $stable(q.capture);
   endproperty
   a_icr_top_no_cap: assert property (p_icr_top_no_cap) else $error("capture while top");

   property p_stopped;
      (q.ctrl_b[2:0] == CS_STOP && !cnt_wr) |=> $stable(q.count);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter ran while stopped");

   property p_ext_rise;
      (q.ctrl_b[2:0] == CS_EXT_RISE && kind != TMC_RESV && !q.ext_prev &&
       external_count_pin) |-> tick;
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("pin edge not counted");

   c_capture:  cover property (cap_edge);
   c_fast_top: cover property (kind == TMC_FAST && tick && at_top);
   c_pfc_turn: cover property (kind == TMC_PFC && tick && at_bot && q.down);

endmodule
`default_nettype wire

// [bench/test_tmc_timer.sv]
/*
 * Self-checking bench for tmc_timer: registers, clocking, capture and waveforms.
 * Assumes tmc_pkg and tmc_timer are compiled first.
 */
`default_nettype none
module test_tmc_timer
   import tmc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 0;
   logic        arst_n = 0;
   logic        cyc = 0;
   logic        stb = 0;
   logic        we = 0;
   logic [7:0]  adr = 0;
   logic [31:0] dat = 0;
   logic [31:0] rd;
   logic        ack, wa, oa, pa, wb, ob, pb;
   logic        cap = 0;
   logic        ext = 0;
   int          fail_count = 0;
   int          check_count = 0;

   // Clock of 50 ns period.
   always #25 clk_sys = ~clk_sys;

   // Device under test; only the two low byte lanes matter.
   tmc_timer i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rd),
      .wb_ack_o(ack), .capture_input_pin(cap), .external_count_pin(ext),
      .wave_out_a(wa), .wave_oe_a(oa), .port_override_a(pa), .wave_out_b(wb),
      .wave_oe_b(ob), .port_override_b(pb));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chkr(input logic [15:0] g, input int lo, input int hi);
      check_count++;
      if ($isunknown(g) || int'(g) < lo || int'(g) > hi)
      begin
         fail_count++;
         $display("unexpected at %0t: got %0d outside %0d..%0d", $time, g, lo, hi);
      end
   endtask

   // One classic cycle; holds the request until ack is sampled high.
   task automatic bus(input logic [5:0] i, input logic w, input logic [15:0] d,
                      output logic [15:0] q);
      int n;
      @(posedge clk_sys);
      cyc <= 1;
      stb <= 1;
      we  <= w;
      adr <= {i, 2'b00};
      dat <= {16'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rd[15:0];
      cyc <= 0;
      stb <= 0;
      if (n >= 20)
         chk(16'h0, 16'h1);
   endtask

   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      logic [15:0] q;
      bus(i, 1, d, q);
   endtask

   task automatic rdc(input logic [5:0] i, input logic [15:0] e);
      logic [15:0] q;
      bus(i, 0, 0, q);
      chk(q, e);
   endtask

   // Reads the capture flag, compares it, then clears it.
   task automatic flag(input logic e);
      logic [15:0] q;
      bus(IDX_FLAGS, 0, 0, q);
      chk(16'(q[FLG_CAPTURE]), 16'(e));
      wr(IDX_FLAGS, 16'h0020);
   endtask

   task automatic hold(input logic c, input logic x, input int n);
      cap <= c;
      ext <= x;
      repeat (n) @(posedge clk_sys);
   endtask

   // Counts high samples of channel B and edges of channel A.
   task automatic meas(input int n, output int h, output int t);
      logic p;
      h = 0;
      t = 0;
      p = wa;
      repeat (n)
      begin
         @(posedge clk_sys);
         h += (wb === 1'b1);
         t += (wa !== p);
         p = wa;
      end
   endtask

   // Stops a hung run.
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      fail_count++;
      stop_test();
   end

   // Main sequence.
   initial
   begin
      int          h, t, e;
      logic [15:0] q;
      int          sh[6] = '{0, 0, 3, 6, 8, 10};
      // Control A, control B, sample cycles, high-count window of channel B.
      int          pw[5][5] = '{'{8'h61, 8'h09, 512, 126, 134},
                                '{8'h31, 8'h09, 512, 378, 386},
                                '{8'h21, 8'h01, 1020, 250, 262},
                                '{8'h31, 8'h01, 1020, 758, 770},
                                '{8'h21, 8'h11, 1020, 250, 262}};
      repeat (10) @(posedge clk_sys);
      arst_n <= 1;
      @(posedge clk_sys);
      chk(16'({oa, pa, ob, pb}), 16'h0);
      rdc(IDX_CTRL_A, 16'h0);
      rdc(IDX_CTRL_B, 16'h0);
      wr(IDX_CTRL_A, 16'hff);
      rdc(IDX_CTRL_A, 16'h00f3);
      wr(IDX_CTRL_B, 16'hff);
      rdc(IDX_CTRL_B, 16'h00df);
      wr(IDX_CTRL_A, 0);
      wr(IDX_CTRL_B, 0);
      wr(6'h3f, 16'hffff);
      rdc(6'h3f, 16'h0);
      $display("test registers done");
      for (int cs = 0; cs < 6; cs++)
      begin
         wr(IDX_COUNT, 0);
         wr(IDX_CTRL_B, 16'(cs));
         repeat (2048) @(posedge clk_sys);
         wr(IDX_CTRL_B, 0);
         bus(IDX_COUNT, 0, 0, q);
         e = (cs == 0) ? 0 : 2048 >> sh[cs];
         chkr(q, e - 1, e + 4);
      end
      for (int s = 6; s < 8; s++)
      begin
         wr(IDX_COUNT, 0);
         wr(IDX_CTRL_B, 16'(s));
         repeat (5)
         begin
            hold(0, 1, 3);
            hold(0, 0, 3);
         end
         rdc(IDX_COUNT, 16'h5);
      end
      $display("test clock select done");
      wr(IDX_CTRL_B, 0);
      wr(IDX_COUNT, 16'h1234);
      wr(IDX_CTRL_B, 16'h40);
      hold(1, 0, 6);
      rdc(IDX_CAPTURE, 16'h1234);
      flag(1);
      hold(0, 0, 6);
      flag(0);
      wr(IDX_CTRL_B, 0);
      wr(IDX_COUNT, 16'h0abc);
      hold(1, 0, 6);
      flag(0);
      hold(0, 0, 6);
      rdc(IDX_CAPTURE, 16'h0abc);
      flag(1);
      wr(IDX_CTRL_B, 16'hc0);
      hold(1, 0, 3);
      hold(0, 0, 8);
      flag(0);
      hold(1, 0, 8);
      flag(1);
      wr(IDX_CTRL_B, 16'h58);
      hold(0, 0, 8);
      flag(0);
      hold(1, 0, 8);
      flag(0);
      $display("test capture done");
      wr(IDX_CTRL_B, 0);
      wr(IDX_PIN_DIR, 16'h3);
      wr(IDX_CMP_A, 16'h9);
      wr(IDX_CMP_B, 16'h40);
      wr(IDX_CTRL_A, 16'h40);
      wr(IDX_COUNT, 0);
      wr(IDX_CTRL_B, 16'h09);
      meas(200, h, t);
      chkr(16'(t), 19, 21);
      chk(16'({pa, oa}), 16'h3);
      wr(IDX_CTRL_A, 16'hc0);
      repeat (20) @(posedge clk_sys);
      chk(16'(wa), 16'h1);
      wr(IDX_CTRL_A, 16'h80);
      repeat (20) @(posedge clk_sys);
      chk(16'(wa), 16'h0);
      // Compare A as an 8-bit top keeps the count in range when the last row picks it as top.
      wr(IDX_CMP_A, 16'h00ff);
      for (int m = 0; m < 5; m++)
      begin
         wr(IDX_CTRL_A, 16'(pw[m][0]));
         wr(IDX_CTRL_B, 16'(pw[m][1]));
         repeat (600) @(posedge clk_sys);
         meas(pw[m][2], h, t);
         chkr(16'(h), pw[m][3], pw[m][4]);
         chk(16'({pb, ob, pa}), 16'h6);
      end
      $display("test waveforms done");
      stop_test();
   end
endmodule
`default_nettype wire
